// File: verilog/user_regs_defines.svh
`ifndef USER_REGS_DEFINES_SVH
`define USER_REGS_DEFINES_SVH

// special register numbers, 10-bit field of the move operations
`define SPR_NUM_W            10
`define SPR_EXCEPTION        10'h001
`define SPR_LINK             10'h008
`define SPR_LOOP_COUNT       10'h009
`define SPR_USER_SCRATCH_0   10'h100
`define SPR_SCRATCH_RO_4     10'h104
`define SPR_SCRATCH_RO_5     10'h105
`define SPR_SCRATCH_RO_6     10'h106
`define SPR_SCRATCH_RO_7     10'h107
`define SPR_TIME_BASE_LOWER  10'h10c
`define SPR_TIME_BASE_UPPER  10'h10d

// exception/carry register, big-endian bit n sits at vector bit 31-n
`define EXC_SUMMARY_BIT      31
`define EXC_OVERFLOW_BIT     30
`define EXC_CARRY_BIT        29
`define EXC_BYTE_COUNT_HI    6
`define EXC_BYTE_COUNT_LO    0
`define EXC_WRITE_MASK       32'he000007f

// reset values
`define REG_RESET            32'h00000000
`define COND_RESET           32'h00000000

`define DATA_WIDTH           32
`define OPERAND_COUNT        32
`define COND_FIELDS          8

`endif

// File: verilog/user_regs_pkg.sv
package user_regs_pkg;

	// first member is the most significant bit, matching big-endian numbering
	typedef struct packed {
		logic less_than_flag;
		logic greater_than_flag;
		logic match_flag;
		logic summary_overflow;
	} cond_field_t;

	// element 0 is the most significant nibble: field 0 at bits 0-3
	typedef cond_field_t [0:7] cond_flags_t;

	typedef enum logic [2:0] {
		COND_NONE,
		COND_FROM_REG,
		COND_FROM_EXC,
		COND_COPY,
		COND_BIT,
		COND_RECORD,
		COND_COMPARE
	} cond_op_t;

	typedef struct packed {
		logic [31:0] upper;
		logic [31:0] lower;
	} time_base_t;

	typedef logic [3:0][31:0] scratch_ro_t;

endpackage

// File: verilog/operand_bank.sv
`timescale 1ns/1ns
`include "user_regs_defines.svh"

module operand_bank #(
	parameter int COUNT = `OPERAND_COUNT,
	parameter int WIDTH = `DATA_WIDTH,
	parameter int IDX_W = $clog2(COUNT)
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic             wr_en,
	input  wire logic [IDX_W-1:0] wr_idx,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic [IDX_W-1:0] rd_a_idx,
	input  wire logic [IDX_W-1:0] rd_b_idx,
	output logic      [WIDTH-1:0] rd_a_data,
	output logic      [WIDTH-1:0] rd_b_data
);

	logic [COUNT-1:0][WIDTH-1:0] bank;

	// refused at elaboration: only the 32 by 32 size of the defines is supported
	if (COUNT != `OPERAND_COUNT || WIDTH != `DATA_WIDTH) begin : g_bad_size
		$error("operand bank must be 32 entries of 32 bits");
	end

	////////////////////////////////////////////////////////////////////////
	genvar i;
	generate
		for (i = 0; i < COUNT; i++) begin : g_entry
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn)
					bank[i] <= `REG_RESET;
				else if (wr_en && wr_idx == IDX_W'(i))
					bank[i] <= wr_data;
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// same-cycle write is forwarded, so a dependent read never sees stale data
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			rd_a_data <= `REG_RESET;
		else if (wr_en && wr_idx == rd_a_idx)
			rd_a_data <= wr_data;
		else
			rd_a_data <= bank[rd_a_idx];
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			rd_b_data <= `REG_RESET;
		else if (wr_en && wr_idx == rd_b_idx)
			rd_b_data <= wr_data;
		else
			rd_b_data <= bank[rd_b_idx];
	end

endmodule

// File: verilog/cond_field_calc.sv
`timescale 1ns/1ns

module cond_field_calc (
	input  wire logic                       is_signed,
	input  wire logic [31:0]                lhs,
	input  wire logic [31:0]                rhs,
	input  wire logic                       summary,
	output user_regs_pkg::cond_field_t      field
);

	logic less;

	// signed compare flips the sign bits so one unsigned compare serves both
	assign less = is_signed ? ({~lhs[31], lhs[30:0]} < {~rhs[31], rhs[30:0]}) : (lhs < rhs);

	assign field.less_than_flag    = less;
	assign field.greater_than_flag = !less && (lhs != rhs);
	assign field.match_flag        = (lhs == rhs);
	assign field.summary_overflow  = summary;

endmodule

// File: verilog/user_register_file.sv
`timescale 1ns/1ns
`include "user_regs_defines.svh"

// What this block does
// - thirty-two 32-bit operand registers, indexed 0 to 31
// - all user registers 32 bits; time base read as two numbered halves
// - no floating-point register storage exists
// - user registers accessible equally in user and privileged mode
// - every special register reached by move-to/move-from by number
// - exception register at 0x001, link 0x008, loop count 0x009
// - branch operations read and update link register implicitly
// - condition register: eight 4-bit fields, field 0 at bits 0-3
// - field bits: less-than, greater-than, equal, summary-overflow copy
// - move-to-condition-fields writes only mask-selected fields from a register
// - exception register bits 0:3 copied into one selected field
// - field copy moves four bits between fields, others unchanged
// - logical operations write single condition bits chosen by index
// - recording arithmetic updates field 0; compare updates named field
// - condition bits exposed to branch logic by selected bit
// - field 0 bits 0-2 from signed compare with zero, bit 3 summary
// - exception register: summary 0, overflow 1, carry 2, byte count 25-31
module user_register_file #(
	parameter int OPERAND_COUNT = `OPERAND_COUNT,
	parameter int DATA_WIDTH    = `DATA_WIDTH
) (
	input  wire logic                        CLK,
	input  wire logic                        RESETN,
	// operand register ports
	input  wire logic                        OPERAND_WR_EN,
	input  wire logic [4:0]                  OPERAND_WR_IDX,
	input  wire logic [31:0]                 OPERAND_WR_DATA,
	input  wire logic [4:0]                  OPERAND_RD_A_IDX,
	input  wire logic [4:0]                  OPERAND_RD_B_IDX,
	output logic      [31:0]                 OPERAND_RD_A_DATA,
	output logic      [31:0]                 OPERAND_RD_B_DATA,
	// special register moves
	input  wire logic                        SPR_RD_EN,
	input  wire logic                        SPR_WR_EN,
	input  wire logic [9:0]                  SPR_NUM,
	input  wire logic [31:0]                 SPR_WR_DATA,
	output logic      [31:0]                 SPR_RD_DATA,
	output logic                             SPR_RD_VALID,
	output logic                             SPR_UNMAPPED,
	input  wire user_regs_pkg::time_base_t   TIME_BASE,
	input  wire user_regs_pkg::scratch_ro_t  SCRATCH_RO,
	// implicit link and loop count updates from branches
	input  wire logic                        LINK_WR_EN,
	input  wire logic [31:0]                 LINK_WR_DATA,
	input  wire logic                        LOOP_WR_EN,
	input  wire logic [31:0]                 LOOP_WR_DATA,
	// arithmetic flag updates
	input  wire logic                        OVERFLOW_EN,
	input  wire logic                        OVERFLOW_VALUE,
	input  wire logic                        CARRY_EN,
	input  wire logic                        CARRY_VALUE,
	// condition operations
	input  wire user_regs_pkg::cond_op_t     COND_OP,
	input  wire logic [0:7]                  COND_FIELD_MASK,
	input  wire logic [2:0]                  COND_DST_FIELD,
	input  wire logic [2:0]                  COND_SRC_FIELD,
	input  wire logic [4:0]                  COND_BIT_IDX,
	input  wire logic                        COND_BIT_VALUE,
	input  wire logic [31:0]                 COND_SRC_DATA,
	input  wire logic [31:0]                 COND_CMP_RHS,
	input  wire logic                        COND_CMP_SIGNED,
	// branch test
	input  wire logic [4:0]                  BRANCH_BIT_IDX,
	output logic                             BRANCH_BIT,
	// current contents
	output user_regs_pkg::cond_flags_t       CONDITION_FLAGS_REG,
	output logic      [31:0]                 FIXED_POINT_EXCEPTION_REG,
	output logic      [31:0]                 LINK_RETURN_ADDRESS,
	output logic      [31:0]                 LOOP_COUNT_REG
);

	user_regs_pkg::cond_flags_t cond;
	user_regs_pkg::cond_flags_t next_cond;
	user_regs_pkg::cond_flags_t src_fields;
	user_regs_pkg::cond_field_t calc_field;
	logic [31:0]                exc;
	logic [31:0]                next_exc;
	logic [31:0]                link;
	logic [31:0]                next_link;
	logic [31:0]                loop_count;
	logic [31:0]                next_loop_count;
	logic [31:0]                user_scratch_0;
	logic [31:0]                next_user_scratch_0;
	logic [31:0]                cond_flat;
	logic [31:0]                calc_lhs;
	logic [31:0]                calc_rhs;
	logic                       calc_signed;
	logic [31:0]                rd_mux;
	logic                       rd_hit;
	logic                       wr_hit;

	// refused at elaboration: the port widths do not follow the parameters
	if (OPERAND_COUNT != `OPERAND_COUNT || DATA_WIDTH != `DATA_WIDTH) begin : g_bad_size
		$error("register file supports only 32 registers of 32 bits");
	end

	////////////////////////////////////////////////////////////////////////
	// only integer storage is built; no floating-point bank
	operand_bank #(
		.COUNT (OPERAND_COUNT),
		.WIDTH (DATA_WIDTH)
	) u_bank (
		.clk       (CLK),
		.resetn    (RESETN),
		.wr_en     (OPERAND_WR_EN),
		.wr_idx    (OPERAND_WR_IDX),
		.wr_data   (OPERAND_WR_DATA),
		.rd_a_idx  (OPERAND_RD_A_IDX),
		.rd_b_idx  (OPERAND_RD_B_IDX),
		.rd_a_data (OPERAND_RD_A_DATA),
		.rd_b_data (OPERAND_RD_B_DATA)
	);

	////////////////////////////////////////////////////////////////////////
	// one comparator serves both recording and compare operations
	always_comb begin
		if (COND_OP == user_regs_pkg::COND_RECORD) begin
			calc_lhs    = COND_SRC_DATA;
			calc_rhs    = 32'h00000000;
			calc_signed = 1'b1;
		end else begin
			calc_lhs    = COND_SRC_DATA;
			calc_rhs    = COND_CMP_RHS;
			calc_signed = COND_CMP_SIGNED;
		end
	end

	// summary bit copied from the final exception state of this cycle
	cond_field_calc u_calc (
		.is_signed (calc_signed),
		.lhs       (calc_lhs),
		.rhs       (calc_rhs),
		.summary   (next_exc[`EXC_SUMMARY_BIT]),
		.field     (calc_field)
	);

	////////////////////////////////////////////////////////////////////////
	// no mode input exists: moves are never blocked by privilege
	assign wr_hit = SPR_WR_EN;

	always_comb begin
		next_exc = exc;
		if (wr_hit && SPR_NUM == `SPR_EXCEPTION)
			next_exc = SPR_WR_DATA & `EXC_WRITE_MASK;
		if (COND_OP == user_regs_pkg::COND_FROM_EXC)
			next_exc[31:28] = 4'h0;
		// hardware set applied last so it wins over a clearing move
		if (OVERFLOW_EN) begin
			next_exc[`EXC_OVERFLOW_BIT] = OVERFLOW_VALUE;
			if (OVERFLOW_VALUE)
				next_exc[`EXC_SUMMARY_BIT] = 1'b1;
		end
		if (CARRY_EN)
			next_exc[`EXC_CARRY_BIT] = CARRY_VALUE;
	end

	always_comb begin
		next_link = link;
		if (wr_hit && SPR_NUM == `SPR_LINK)
			next_link = SPR_WR_DATA;
		if (LINK_WR_EN)
			next_link = LINK_WR_DATA;
	end

	always_comb begin
		next_loop_count = loop_count;
		if (wr_hit && SPR_NUM == `SPR_LOOP_COUNT)
			next_loop_count = SPR_WR_DATA;
		if (LOOP_WR_EN)
			next_loop_count = LOOP_WR_DATA;
	end

	always_comb begin
		next_user_scratch_0 = user_scratch_0;
		if (wr_hit && SPR_NUM == `SPR_USER_SCRATCH_0)
			next_user_scratch_0 = SPR_WR_DATA;
	end

	////////////////////////////////////////////////////////////////////////
	assign src_fields = user_regs_pkg::cond_flags_t'(COND_SRC_DATA);

	always_comb begin
		next_cond = cond;
		cond_flat = 32'(cond);
		unique case (COND_OP)
			user_regs_pkg::COND_NONE: begin
				next_cond = cond;
			end
			user_regs_pkg::COND_FROM_REG: begin
				for (int k = 0; k < `COND_FIELDS; k++) begin
					if (COND_FIELD_MASK[k])
						next_cond[k] = src_fields[k];
				end
			end
			user_regs_pkg::COND_FROM_EXC: begin
				next_cond[COND_DST_FIELD] = user_regs_pkg::cond_field_t'(exc[31:28]);
			end
			user_regs_pkg::COND_COPY: begin
				next_cond[COND_DST_FIELD] = cond[COND_SRC_FIELD];
			end
			user_regs_pkg::COND_BIT: begin
				// big-endian index: bit 0 is the most significant
				cond_flat[5'd31 - COND_BIT_IDX] = COND_BIT_VALUE;
				next_cond = user_regs_pkg::cond_flags_t'(cond_flat);
			end
			user_regs_pkg::COND_RECORD: begin
				next_cond[0] = calc_field;
			end
			user_regs_pkg::COND_COMPARE: begin
				next_cond[COND_DST_FIELD] = calc_field;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN)
			cond <= user_regs_pkg::cond_flags_t'(`COND_RESET);
		else
			cond <= next_cond;
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN)
			exc <= `REG_RESET;
		else
			exc <= next_exc;
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN)
			link <= `REG_RESET;
		else
			link <= next_link;
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN)
			loop_count <= `REG_RESET;
		else
			loop_count <= next_loop_count;
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN)
			user_scratch_0 <= `REG_RESET;
		else
			user_scratch_0 <= next_user_scratch_0;
	end

	assign CONDITION_FLAGS_REG       = cond;
	assign FIXED_POINT_EXCEPTION_REG = exc;
	assign LINK_RETURN_ADDRESS       = link;
	assign LOOP_COUNT_REG            = loop_count;

	////////////////////////////////////////////////////////////////////////
	// reads decode the next values, forwarding a same-cycle write
	always_comb begin
		rd_hit = 1'b1;
		unique case (SPR_NUM)
			`SPR_EXCEPTION:       rd_mux = next_exc;
			`SPR_LINK:            rd_mux = next_link;
			`SPR_LOOP_COUNT:      rd_mux = next_loop_count;
			`SPR_USER_SCRATCH_0:  rd_mux = next_user_scratch_0;
			`SPR_SCRATCH_RO_4:    rd_mux = SCRATCH_RO[0];
			`SPR_SCRATCH_RO_5:    rd_mux = SCRATCH_RO[1];
			`SPR_SCRATCH_RO_6:    rd_mux = SCRATCH_RO[2];
			`SPR_SCRATCH_RO_7:    rd_mux = SCRATCH_RO[3];
			`SPR_TIME_BASE_LOWER: rd_mux = TIME_BASE.lower;
			`SPR_TIME_BASE_UPPER: rd_mux = TIME_BASE.upper;
			default: begin
				rd_mux = 32'h00000000;
				rd_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN)
			SPR_RD_DATA <= `REG_RESET;
		else if (SPR_RD_EN)
			SPR_RD_DATA <= rd_mux;
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN)
			SPR_RD_VALID <= 1'b0;
		else
			SPR_RD_VALID <= SPR_RD_EN;
	end

	// read-only and unknown numbers ignore writes; unknown ones are flagged
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN)
			SPR_UNMAPPED <= 1'b0;
		else
			SPR_UNMAPPED <= (SPR_RD_EN || SPR_WR_EN) && !rd_hit;
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN)
			BRANCH_BIT <= 1'b0;
		else
			BRANCH_BIT <= next_cond[BRANCH_BIT_IDX[4:2]][2'd3 - BRANCH_BIT_IDX[1:0]];
	end

endmodule

// File: tb/user_regs_asserts.sv
`timescale 1ns/1ns
`include "user_regs_defines.svh"

module user_regs_asserts #(
	parameter int OPERAND_COUNT = 32,
	parameter int DATA_WIDTH    = 32
) (
	input wire logic                       CLK,
	input wire logic                       RESETN,
	input wire logic                       SPR_RD_EN,
	input wire logic                       SPR_WR_EN,
	input wire logic [9:0]                 SPR_NUM,
	input wire logic [31:0]                SPR_WR_DATA,
	input wire logic                       SPR_RD_VALID,
	input wire logic                       SPR_UNMAPPED,
	input wire logic                       LINK_WR_EN,
	input wire logic [31:0]                LINK_WR_DATA,
	input wire logic                       OVERFLOW_EN,
	input wire logic                       OVERFLOW_VALUE,
	input wire user_regs_pkg::cond_op_t    COND_OP,
	input wire logic [0:7]                 COND_FIELD_MASK,
	input wire logic [31:0]                COND_SRC_DATA,
	input wire logic [4:0]                 BRANCH_BIT_IDX,
	input wire logic                       BRANCH_BIT,
	input wire user_regs_pkg::cond_flags_t CONDITION_FLAGS_REG,
	input wire logic [31:0]                FIXED_POINT_EXCEPTION_REG,
	input wire logic [31:0]                LINK_RETURN_ADDRESS
);
	logic [31:0] cf;
	logic [31:0] mexp;

	assign cf = CONDITION_FLAGS_REG;

	// field k of the mask spreads over the nibble that big-endian numbering gives it
	always_comb begin
		for (int k = 0; k < 8; k++) begin
			mexp[31-4*k -: 4] = {4{COND_FIELD_MASK[k]}};
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);

	////////////////////////////////////////////////////////////////////////
	sequence s_record;
		COND_OP == user_regs_pkg::COND_RECORD;
	endsequence

	// no local variable: the recorded result is recovered with $past
	property p_record;
		s_record |=>
			cf[31:28] == {$past(COND_SRC_DATA[31]),
				!$past(COND_SRC_DATA[31]) && $past(COND_SRC_DATA) != 32'h0,
				$past(COND_SRC_DATA) == 32'h0,
				FIXED_POINT_EXCEPTION_REG[31]};
	endproperty

	a_rd_valid_pulse: assert property (1'b1 |=> SPR_RD_VALID == $past(SPR_RD_EN))
		else $error("read valid does not follow read request");
	a_unmapped_flag: assert property ((SPR_RD_EN || SPR_WR_EN) && SPR_NUM > 10'h10d
		|=> SPR_UNMAPPED) else $error("unknown number not flagged");
	a_link_move: assert property (SPR_WR_EN && SPR_NUM == `SPR_LINK && !LINK_WR_EN
		|=> LINK_RETURN_ADDRESS == $past(SPR_WR_DATA)) else $error("link move lost");
	a_link_implicit: assert property (LINK_WR_EN
		|=> LINK_RETURN_ADDRESS == $past(LINK_WR_DATA)) else $error("implicit link lost");
	a_record_field: assert property (p_record)
		else $error("field zero wrong after record");
	a_mask_fields: assert property (COND_OP == user_regs_pkg::COND_FROM_REG |=>
		cf == (($past(cf) & ~$past(mexp)) | ($past(COND_SRC_DATA) & $past(mexp))))
		else $error("masked field move wrong");
	a_branch_bit: assert property (1'b1 |=> BRANCH_BIT == cf[31 - $past(BRANCH_BIT_IDX)])
		else $error("branch bit wrong");
	a_summary_sticky: assert property (OVERFLOW_EN && OVERFLOW_VALUE
		|=> FIXED_POINT_EXCEPTION_REG[31:30] == 2'b11) else $error("overflow not recorded");
endmodule

bind user_register_file user_regs_asserts #(
	.OPERAND_COUNT(OPERAND_COUNT),
	.DATA_WIDTH   (DATA_WIDTH)
) u_chk (
	.CLK(CLK), .RESETN(RESETN), .SPR_RD_EN(SPR_RD_EN), .SPR_WR_EN(SPR_WR_EN),
	.SPR_NUM(SPR_NUM), .SPR_WR_DATA(SPR_WR_DATA), .SPR_RD_VALID(SPR_RD_VALID),
	.SPR_UNMAPPED(SPR_UNMAPPED), .LINK_WR_EN(LINK_WR_EN), .LINK_WR_DATA(LINK_WR_DATA),
	.OVERFLOW_EN(OVERFLOW_EN), .OVERFLOW_VALUE(OVERFLOW_VALUE), .COND_OP(COND_OP),
	.COND_FIELD_MASK(COND_FIELD_MASK), .COND_SRC_DATA(COND_SRC_DATA),
	.BRANCH_BIT_IDX(BRANCH_BIT_IDX), .BRANCH_BIT(BRANCH_BIT),
	.CONDITION_FLAGS_REG(CONDITION_FLAGS_REG),
	.FIXED_POINT_EXCEPTION_REG(FIXED_POINT_EXCEPTION_REG),
	.LINK_RETURN_ADDRESS(LINK_RETURN_ADDRESS)
);

// File: tb/pipe_model.sv
`timescale 1ns/1ns

module pipe_model #(
	parameter logic [63:0] TB_VAL = 64'h0123456789abcdef
) (
	output user_regs_pkg::time_base_t  time_base,
	output user_regs_pkg::scratch_ro_t scratch_ro
);
	// counting lives elsewhere; a frozen value keeps the two half reads comparable
	assign time_base  = TB_VAL;
	assign scratch_ro = {32'h70707070, 32'h60606060, 32'h50505050, 32'h40404040};
endmodule

// File: tb/user_register_file_tb.sv
`timescale 1ns/1ns
`include "user_regs_defines.svh"

module user_register_file_tb;
	logic                       CLK;
	logic                       RESETN;
	logic                       we, sre, swe, lwe, pwe, ove, ovv, cae, cav, bv, sg;
	logic [4:0]                 wi, ra, rb, bi, cbi;
	logic [31:0]                wd, sd, ld, pd, cs, cr;
	logic [9:0]                 sn;
	logic [0:7]                 msk;
	logic [2:0]                 df, sf;
	user_regs_pkg::cond_op_t    op;
	user_regs_pkg::time_base_t  tbv;
	user_regs_pkg::scratch_ro_t so;
	user_regs_pkg::cond_flags_t cf;
	logic [31:0]                rda, rdb, srd, fixed_point_exception_reg, lr, lc;
	logic                       sv, su, bb;
	int                         err_total, n_checks, cyc;

	pipe_model u_pipe (.time_base(tbv), .scratch_ro(so));

	user_register_file u_dut (
		.CLK(CLK), .RESETN(RESETN), .OPERAND_WR_EN(we), .OPERAND_WR_IDX(wi),
		.OPERAND_WR_DATA(wd), .OPERAND_RD_A_IDX(ra), .OPERAND_RD_B_IDX(rb),
		.OPERAND_RD_A_DATA(rda), .OPERAND_RD_B_DATA(rdb), .SPR_RD_EN(sre),
		.SPR_WR_EN(swe), .SPR_NUM(sn), .SPR_WR_DATA(sd), .SPR_RD_DATA(srd),
		.SPR_RD_VALID(sv), .SPR_UNMAPPED(su), .TIME_BASE(tbv), .SCRATCH_RO(so),
		.LINK_WR_EN(lwe), .LINK_WR_DATA(ld), .LOOP_WR_EN(pwe), .LOOP_WR_DATA(pd),
		.OVERFLOW_EN(ove), .OVERFLOW_VALUE(ovv), .CARRY_EN(cae), .CARRY_VALUE(cav),
		.COND_OP(op), .COND_FIELD_MASK(msk), .COND_DST_FIELD(df), .COND_SRC_FIELD(sf),
		.COND_BIT_IDX(cbi), .COND_BIT_VALUE(bv), .COND_SRC_DATA(cs), .COND_CMP_RHS(cr),
		.COND_CMP_SIGNED(sg), .BRANCH_BIT_IDX(bi), .BRANCH_BIT(bb),
		.CONDITION_FLAGS_REG(cf), .FIXED_POINT_EXCEPTION_REG(fixed_point_exception_reg),
		.LINK_RETURN_ADDRESS(lr), .LOOP_COUNT_REG(lc)
	);

	initial begin
		CLK = 1'b0;
		forever #50 CLK = ~CLK;
	end

	////////////////////////////////////////////////////////////////////////
	task test_done;
		if (err_total == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %0t got %h want %h", $time, got, exp);
		end
	endtask

	// requests last one edge; release them there and look once outputs settle
	task tick;
		@(posedge CLK);
		we  <= 1'b0;
		sre <= 1'b0;
		swe <= 1'b0;
		lwe <= 1'b0;
		pwe <= 1'b0;
		ove <= 1'b0;
		cae <= 1'b0;
		op  <= user_regs_pkg::COND_NONE;
		#1;
	endtask

	task spr(input logic w, input logic [9:0] n, input logic [31:0] d);
		@(posedge CLK);
		swe <= w;
		sre <= !w;
		sn  <= n;
		sd  <= d;
		tick();
	endtask

	task cop(input user_regs_pkg::cond_op_t o, input logic [31:0] exp);
		op <= o;
		tick();
		chk(cf, exp);
	endtask

	function automatic logic [31:0] gv(input int i);
		return 32'h5a000000 ^ (32'(i) * 32'h01010101);
	endfunction

	////////////////////////////////////////////////////////////////////////
	task t_operands;
		for (int i = 0; i < 32; i++) begin
			@(posedge CLK);
			we <= 1'b1;
			wi <= 5'(i);
			wd <= gv(i);
			ra <= 5'(i);
			tick();
			chk(rda, gv(i));
		end
		for (int i = 0; i < 32; i++) begin
			@(posedge CLK);
			ra <= 5'(31 - i);
			rb <= 5'(i);
			@(posedge CLK);
			#1;
			chk(rda, gv(31 - i));
			chk(rdb, gv(i));
		end
	endtask

	task t_spr;
		logic [9:0]  num [8];
		logic [31:0] exp [8];
		num = '{`SPR_EXCEPTION, `SPR_LINK, `SPR_LOOP_COUNT, `SPR_USER_SCRATCH_0,
			`SPR_SCRATCH_RO_4, `SPR_SCRATCH_RO_7, `SPR_TIME_BASE_LOWER, `SPR_TIME_BASE_UPPER};
		exp = '{32'he000007f, 32'hffffffff, 32'hffffffff, 32'hffffffff,
			32'h40404040, 32'h70707070, 32'h89abcdef, 32'h01234567};
		for (int i = 0; i < 8; i++) begin
			spr(1'b1, num[i], 32'hffffffff);
			spr(1'b0, num[i], 32'h0);
			chk(srd, exp[i]);
			chk({31'h0, sv}, 32'h1);
		end
		spr(1'b1, 10'h3ff, 32'h0);
		chk({31'h0, su}, 32'h1);
		@(posedge CLK);
		swe <= 1'b1;
		sre <= 1'b1;
		sn  <= `SPR_LINK;
		sd  <= 32'h0badcafe;
		tick();
		chk(srd, 32'h0badcafe);
	endtask

	task t_implicit;
		@(posedge CLK);
		lwe <= 1'b1;
		ld  <= 32'h00001000;
		pwe <= 1'b1;
		pd  <= 32'h00000007;
		swe <= 1'b1;
		sn  <= `SPR_LINK;
		sd  <= 32'h0;
		tick();
		chk(lr, 32'h00001000);
		chk(lc, 32'h00000007);
		spr(1'b1, `SPR_EXCEPTION, 32'h0);
		@(posedge CLK);
		ove <= 1'b1;
		ovv <= 1'b1;
		cae <= 1'b1;
		cav <= 1'b1;
		tick();
		chk(fixed_point_exception_reg, 32'he0000000);
	endtask

	task t_cond;
		@(posedge CLK);
		msk <= 8'b10100001;
		cs  <= 32'h12345678;
		cop(user_regs_pkg::COND_FROM_REG, 32'h10300008);
		sf <= 3'd2;
		df <= 3'd5;
		cop(user_regs_pkg::COND_COPY, 32'h10300308);
		df <= 3'd1;
		cop(user_regs_pkg::COND_FROM_EXC, 32'h1e300308);
		chk(fixed_point_exception_reg, 32'h0);
		cbi <= 5'd31;
		bv  <= 1'b1;
		cop(user_regs_pkg::COND_BIT, 32'h1e300309);
		cs  <= 32'h80000000;
		ove <= 1'b1;
		cop(user_regs_pkg::COND_RECORD, 32'h9e300309);
		cs <= 32'h5;
		cr <= 32'hffffffff;
		sg <= 1'b1;
		df <= 3'd3;
		cop(user_regs_pkg::COND_COMPARE, 32'h9e350309);
		sg <= 1'b0;
		df <= 3'd4;
		cop(user_regs_pkg::COND_COMPARE, 32'h9e359309);
		for (int i = 0; i < 32; i++) begin
			@(posedge CLK);
			bi <= 5'(i);
			@(posedge CLK);
			#1;
			chk({31'h0, bb}, (32'h9e359309 >> (31 - i)) & 32'h1);
		end
	endtask

	// a second reset in mid-run must return the condition, exception, link and operand registers to reset values
	task t_reset;
		@(posedge CLK);
		RESETN <= 1'b0;
		@(posedge CLK);
		#1;
		chk(cf, `COND_RESET);
		chk(fixed_point_exception_reg, `REG_RESET);
		chk(lr, `REG_RESET);
		@(posedge CLK);
		RESETN <= 1'b1;
		@(posedge CLK);
		#1;
		chk(rda, `REG_RESET);
	endtask

	////////////////////////////////////////////////////////////////////////
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 2000) begin
			err_total++;
			test_done();
		end
	end

	initial begin
		RESETN = 1'b0;
		{we, sre, swe, lwe, pwe, ove, ovv, cae, cav, bv, sg} = '0;
		{wi, ra, rb, bi, cbi} = '0;
		{wd, sd, ld, pd, cs, cr} = '0;
		sn  = 10'h0;
		msk = 8'h0;
		df  = 3'h0;
		sf  = 3'h0;
		op  = user_regs_pkg::COND_NONE;
		repeat (4) @(posedge CLK);
		RESETN <= 1'b1;
		t_operands();
		t_spr();
		t_implicit();
		t_cond();
		t_reset();
		test_done();
	end
endmodule
